// ### design/asu_pkg.sv
// package: register map, field positions, reset values and timing counts of the async serial unit
package asu_pkg;
   localparam logic [15:0] ASU_MODE_ADDR = 16'hffa0;
   localparam logic [15:0] ASU_STAT_ADDR = 16'hffa1;
   localparam logic [15:0] ASU_BAUD_ADDR = 16'hffa2;
   localparam logic [15:0] ASU_DATA_ADDR = 16'hffa3;
   localparam int ASU_TXE_POS = 7;
   localparam int ASU_RXE_POS = 6;
   localparam int ASU_PS_HI_POS = 5;
   localparam int ASU_PS_LO_POS = 4;
   localparam int ASU_CL_POS = 3;
   localparam int ASU_SL_POS = 2;
   localparam int ASU_ISRM_POS = 1;
   localparam int ASU_PE_POS = 2;
   localparam int ASU_FE_POS = 1;
   localparam int ASU_OVE_POS = 0;
   localparam int ASU_TPS_LO = 4;
   localparam int ASU_MDL_LO = 0;
   localparam logic [7:0] ASU_MODE_RST = 8'h00;
   localparam logic [7:0] ASU_STAT_RST = 8'h00;
   localparam logic [7:0] ASU_BAUD_RST = 8'h00;
   localparam logic [7:0] ASU_TXD_RST = 8'hff;
   localparam logic [7:0] ASU_RXB_RST = 8'hff;
   localparam logic [3:0] ASU_MDL_BAD = 4'hf;
   localparam logic [4:0] ASU_DIV_BASE = 5'h10;
   localparam logic [1:0] ASU_PAR_NONE = 2'h0;
   localparam logic [1:0] ASU_PAR_ZERO = 2'h1;
   localparam logic [1:0] ASU_PAR_ODD = 2'h2;
   localparam logic [1:0] ASU_PAR_EVEN = 2'h3;
   localparam int ASU_OVS = 2;
   typedef enum logic [2:0] {ASU_IDLE, ASU_START, ASU_DATA, ASU_PAR, ASU_STOP} asu_state_e;
endpackage : asu_pkg

// ### design/asu_core.sv
// async serial unit: baud generator, transmitter, receiver and byte registers
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - full duplex, one character after start bit
// - external baud clock pin can source rate
// - write to transmit register starts sending
// - character bit: 0 seven, 1 eight bits
// - shared address: read buffer, write shifter
// - shift register fills, then copies to buffer
// - seven-bit receive clears buffer top bit
// - frame with start, optional parity, stops
// - enable bits pick stop, rx, tx, both
// - parity: none, zero, odd, even
// - stop length bit gives one or two
// - receiver checks only one stop bit
// - mask bit suppresses completion on error
// - status: zeros then parity, framing, overrun
// - parity flag on parity mismatch in odd or even mode only
// - framing flag when stop bit missing
// - overrun when buffer unread at completion
// - overrun repeats until buffer read
// - source select: pin or clock over 2^n
// - divisor select k divides by 16+k for even k, 17+k for odd k; 15 stops the generator
module asu_core (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   input wire logic serial_input_pin,
   input wire logic external_baud_clock_pin,
   output logic serial_output_pin,
   output logic serial_output_oe_n,
   output logic rx_done_irq,
   output logic tx_done_irq
);
   import asu_pkg::*;

   logic [7:0] serial_mode_control_r;
   logic [7:0] baud_generator_control_r;
   logic [2:0] rx_s_r;
   logic [2:0] ck_s_r;
   logic rx_lvl_r;
   logic ck_lvl_r;
   logic ck_prev_r;
   logic rx_prev_r;
   logic [6:0] pre_r;
   logic [4:0] bdiv_r;
   logic tick_r;
   logic [7:0] cpu_rdata_r;
   logic [7:0] transmit_data_shifter_r;
   asu_state_e tx_st_r;
   logic [3:0] tx_cnt_r;
   logic tx_half_r;
   logic tx_stop2_r;
   logic tx_pin_r;
   logic tx_oe_n_r;
   logic tx_irq_r;
   asu_state_e rx_st_r;
   logic [3:0] rx_cnt_r;
   logic rx_half_r;
   logic [7:0] receive_serial_shifter_r;
   logic [7:0] receive_data_holding_r;
   logic rx_par_r;
   logic unread_r;
   logic [7:0] receive_error_status_r;
   logic rx_irq_r;

   function automatic logic par_bit(input logic [7:0] d, input logic [1:0] ps, input logic cl);
      logic x;
      x = ^(cl ? d : {1'b0, d[6:0]});
      case (ps)
         ASU_PAR_ODD: par_bit = ~x;
         ASU_PAR_EVEN: par_bit = x;
         default: par_bit = 1'b0;
      endcase
   endfunction : par_bit

   // mode fields
   wire txe = serial_mode_control_r[ASU_TXE_POS];
   wire rxe = serial_mode_control_r[ASU_RXE_POS];
   wire [1:0] ps = {serial_mode_control_r[ASU_PS_HI_POS], serial_mode_control_r[ASU_PS_LO_POS]};
   wire cl = serial_mode_control_r[ASU_CL_POS];
   wire sl = serial_mode_control_r[ASU_SL_POS];
   wire isrm = serial_mode_control_r[ASU_ISRM_POS];
   wire [2:0] tps = baud_generator_control_r[ASU_TPS_LO +: 3];
   wire [3:0] mdl = baud_generator_control_r[ASU_MDL_LO +: 4];
   wire [3:0] nbits = cl ? 4'h8 : 4'h7;

   // register decode
   wire wr_mode = cpu_wr && cpu_addr == ASU_MODE_ADDR;
   wire wr_baud = cpu_wr && cpu_addr == ASU_BAUD_ADDR;
   wire wr_tx = cpu_wr && cpu_addr == ASU_DATA_ADDR;
   wire rd_rxb = cpu_rd && cpu_addr == ASU_DATA_ADDR;
   wire [7:0] rd_mux = (cpu_addr == ASU_MODE_ADDR) ? serial_mode_control_r :
                       (cpu_addr == ASU_STAT_ADDR) ? receive_error_status_r :
                       (cpu_addr == ASU_BAUD_ADDR) ? baud_generator_control_r :
                       (cpu_addr == ASU_DATA_ADDR) ? receive_data_holding_r : 8'h00;

   // baud source: pin edge or clock over 2^n
   wire ck_rise = ck_lvl_r && !ck_prev_r;
   wire [6:0] pre_mask = 7'(({7'h00, 1'b1} << tps) - 8'h01);
   wire src_en = (tps == 3'h0) ? ck_rise : ((pre_r & pre_mask) == pre_mask);
   wire [4:0] div_top = 5'(ASU_DIV_BASE + {1'b0, mdl} - 5'h01);
   wire div_ok = mdl != ASU_MDL_BAD;

   // receive line: three flops, level taken when two agree
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_s_r <= 3'h7;
         rx_lvl_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_s_r <= {rx_s_r[1:0], serial_input_pin};
         if (rx_s_r[1] == rx_s_r[2]) rx_lvl_r <= rx_s_r[2];
         rx_prev_r <= rx_lvl_r;
      end
   end

   // external baud clock: same filter, rising edges counted
   always_ff @(posedge mclk) begin
      if (srst) begin
         ck_s_r <= 3'h0;
         ck_lvl_r <= 1'b0;
         ck_prev_r <= 1'b0;
      end else begin
         ck_s_r <= {ck_s_r[1:0], external_baud_clock_pin};
         if (ck_s_r[1] == ck_s_r[2]) ck_lvl_r <= ck_s_r[2];
         ck_prev_r <= ck_lvl_r;
      end
   end

   // tick runs at twice the bit rate: half-bit steps
   always_ff @(posedge mclk) begin
      if (srst) begin
         pre_r <= 7'h00;
         bdiv_r <= 5'h00;
         tick_r <= 1'b0;
      end else begin
         pre_r <= 7'(pre_r + 7'h01);
         tick_r <= 1'b0;
         if (src_en && div_ok) begin
            if (bdiv_r >= 5'(div_top >> 1)) begin
               bdiv_r <= 5'h00;
               tick_r <= 1'b1;
            end else begin
               bdiv_r <= 5'(bdiv_r + 5'h01);
            end
         end
      end
   end

   // mode register: bit 0 always reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         serial_mode_control_r <= ASU_MODE_RST;
      end else if (wr_mode) begin
         serial_mode_control_r <= {cpu_wdata[7:1], 1'b0};
      end
   end

   // baud control: bit 7 always reads zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         baud_generator_control_r <= ASU_BAUD_RST;
      end else if (wr_baud) begin
         baud_generator_control_r <= {1'b0, cpu_wdata[6:0]};
      end
   end

   // read data holds until the next read
   always_ff @(posedge mclk) begin
      if (srst) begin
         cpu_rdata_r <= 8'h00;
      end else if (cpu_rd) begin
         cpu_rdata_r <= rd_mux;
      end
   end

   // transmitter
   always_ff @(posedge mclk) begin
      if (srst) begin
         transmit_data_shifter_r <= ASU_TXD_RST;
         tx_st_r <= ASU_IDLE;
         tx_cnt_r <= 4'h0;
         tx_half_r <= 1'b0;
         tx_stop2_r <= 1'b0;
         tx_pin_r <= 1'b1;
         tx_oe_n_r <= 1'b1;
         tx_irq_r <= 1'b0;
      end else begin
         tx_irq_r <= 1'b0;
         tx_oe_n_r <= ~txe;
         if (wr_tx && txe && tx_st_r == ASU_IDLE) begin
            transmit_data_shifter_r <= cpu_wdata;
            tx_st_r <= ASU_START;
            tx_cnt_r <= 4'h0;
            tx_half_r <= 1'b0;
            tx_pin_r <= 1'b0;
         end else if (!txe) begin
            tx_st_r <= ASU_IDLE;
            tx_pin_r <= 1'b1;
         end else if (tick_r && tx_st_r != ASU_IDLE) begin
            tx_half_r <= ~tx_half_r;
            if (tx_half_r) begin
               case (tx_st_r)
                  ASU_START: begin
                     tx_st_r <= ASU_DATA;
                     tx_pin_r <= transmit_data_shifter_r[0];
                     tx_cnt_r <= 4'h1;
                  end
                  ASU_DATA: begin
                     if (tx_cnt_r < nbits) begin
                        tx_pin_r <= transmit_data_shifter_r[tx_cnt_r[2:0]];
                        tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
                     end else if (ps != ASU_PAR_NONE) begin
                        tx_st_r <= ASU_PAR;
                        tx_pin_r <= par_bit(transmit_data_shifter_r, ps, cl);
                     end else begin
                        tx_st_r <= ASU_STOP;
                        tx_pin_r <= 1'b1;
                        tx_stop2_r <= sl;
                     end
                  end
                  ASU_PAR: begin
                     tx_st_r <= ASU_STOP;
                     tx_pin_r <= 1'b1;
                     tx_stop2_r <= sl;
                  end
                  ASU_STOP: begin
                     if (tx_stop2_r) begin
                        tx_stop2_r <= 1'b0;
                     end else begin
                        tx_st_r <= ASU_IDLE;
                        tx_irq_r <= 1'b1;
                     end
                  end
                  default: tx_st_r <= ASU_IDLE;
               endcase
            end
         end
      end
   end

   // receiver: first tick after a falling edge checks start, then one sample per bit
   wire [7:0] rx_data = cl ? receive_serial_shifter_r : {1'b0, receive_serial_shifter_r[7:1]};
   wire par_err = (ps == ASU_PAR_ODD || ps == ASU_PAR_EVEN) &&
                  (rx_par_r != par_bit(rx_data, ps, cl));
   wire fr_err = !rx_lvl_r;
   wire ov_err = unread_r;
   wire any_err = par_err || fr_err || ov_err;
   wire rx_end = rxe && tick_r && rx_half_r && rx_st_r == ASU_STOP;

   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_st_r <= ASU_IDLE;
         rx_cnt_r <= 4'h0;
         rx_half_r <= 1'b0;
         receive_serial_shifter_r <= 8'h00;
         rx_par_r <= 1'b0;
      end else if (!rxe) begin
         rx_st_r <= ASU_IDLE;
      end else if (rx_st_r == ASU_IDLE) begin
         if (!rx_lvl_r && rx_prev_r) begin
            rx_st_r <= ASU_START;
            rx_half_r <= 1'b1;
         end
      end else if (tick_r) begin
         rx_half_r <= ~rx_half_r;
         if (rx_half_r) begin
            case (rx_st_r)
               ASU_START: begin
                  rx_st_r <= rx_lvl_r ? ASU_IDLE : ASU_DATA;
                  rx_cnt_r <= 4'h0;
               end
               ASU_DATA: begin
                  receive_serial_shifter_r <= {rx_lvl_r, receive_serial_shifter_r[7:1]};
                  rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
                  if (4'(rx_cnt_r + 4'h1) == nbits) rx_st_r <= (ps != ASU_PAR_NONE) ? ASU_PAR : ASU_STOP;
               end
               ASU_PAR: begin
                  rx_par_r <= rx_lvl_r;
                  rx_st_r <= ASU_STOP;
               end
               ASU_STOP: rx_st_r <= ASU_IDLE;
               default: rx_st_r <= ASU_IDLE;
            endcase
         end
      end
   end

   // receive buffer takes the character at the stop sample
   always_ff @(posedge mclk) begin
      if (srst) begin
         receive_data_holding_r <= ASU_RXB_RST;
      end else if (rx_end) begin
         receive_data_holding_r <= rx_data;
      end
   end

   // status rewritten at every character end
   always_ff @(posedge mclk) begin
      if (srst) begin
         receive_error_status_r <= ASU_STAT_RST;
      end else if (rx_end) begin
         receive_error_status_r <= {5'h00, par_err, fr_err, ov_err};
      end
   end

   // unread marker: a completion beats a same-cycle read
   always_ff @(posedge mclk) begin
      if (srst) begin
         unread_r <= 1'b0;
      end else if (rx_end) begin
         unread_r <= 1'b1;
      end else if (rd_rxb) begin
         unread_r <= 1'b0;
      end
   end

   // completion pulse, held back on error when masked
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_irq_r <= 1'b0;
      end else begin
         rx_irq_r <= rx_end && !(any_err && isrm);
      end
   end

   assign cpu_rdata = cpu_rdata_r;
   assign serial_output_pin = tx_pin_r;
   assign serial_output_oe_n = tx_oe_n_r;
   assign rx_done_irq = rx_irq_r;
   assign tx_done_irq = tx_irq_r;
endmodule : asu_core
`default_nettype wire

// ### test/asu_core_asserts.sv
// checker: port-level properties of the async serial unit
`timescale 1ns/1ns
`default_nettype none
module asu_core_asserts import asu_pkg::*; (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_wr,
   input wire logic cpu_rd,
   input wire logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata,
   input wire logic serial_input_pin,
   input wire logic external_baud_clock_pin,
   input wire logic serial_output_pin,
   input wire logic serial_output_oe_n,
   input wire logic rx_done_irq,
   input wire logic tx_done_irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   wire addr_hit = cpu_addr inside {ASU_MODE_ADDR, ASU_STAT_ADDR, ASU_BAUD_ADDR, ASU_DATA_ADDR};
   reset_idle_a: assert property (disable iff (1'b0) srst |=> serial_output_pin && serial_output_oe_n)
      else $error("outputs not idle after reset");
   tx_gate_a: assert property ($fell(serial_output_pin) |-> !serial_output_oe_n)
      else $error("line driven low while transmitter off");
   start_hold_a: assert property ($fell(serial_output_pin) |=> !serial_output_pin [*8])
      else $error("start bit too short");
   rx_pulse_a: assert property (rx_done_irq |=> !rx_done_irq) else $error("rx pulse too long");
   tx_pulse_a: assert property (tx_done_irq |=> !tx_done_irq) else $error("tx pulse too long");
   stop_high_a: assert property (tx_done_irq |-> serial_output_pin) else $error("line low at tx end");
   unmapped_zero_a: assert property (cpu_rd && !addr_hit |=> cpu_rdata == 8'h00)
      else $error("unmapped read not zero");
   stat_upper_a: assert property (cpu_rd && cpu_addr == ASU_STAT_ADDR |=> cpu_rdata[7:3] == 5'h00)
      else $error("status upper bits not zero");
endmodule : asu_core_asserts
`default_nettype wire

// ### test/asu_remote.sv
// partner: remote serial device, frame sender and line sampler
`timescale 1ns/1ns
`default_nettype none
module asu_remote #(parameter int BIT_NS = 320) (
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   // start, lsb first data, optional parity, one stop, then idle high
   task automatic send(input logic [7:0] d, input int nb, input int par, input logic stp);
      line_out = 1'b0;
      #BIT_NS;
      for (int i = 0; i < nb; i++) begin
         line_out = d[i];
         #BIT_NS;
      end
      if (par != 0) begin
         line_out = (par == 2);
         #BIT_NS;
      end
      line_out = stp;
      #BIT_NS;
      line_out = 1'b1;
      #BIT_NS;
   endtask : send
   // samples start bit and the n bits after it at mid-bit
   task automatic grab(input int n, output logic [11:0] v);
      v = 12'h000;
      wait (line_in === 1'b0);
      #(BIT_NS / 2);
      for (int i = 0; i <= n; i++) begin
         v[i] = line_in;
         #BIT_NS;
      end
   endtask : grab
endmodule : asu_remote
`default_nettype wire

// ### test/testbench.sv
// testbench: register, transmit and receive checks of the async serial unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import asu_pkg::*;
   localparam int BIT = 320;
   logic mclk, srst, cpu_wr, cpu_rd, ext_ck;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata, r;
   logic [11:0] v;
   wire logic [7:0] cpu_rdata;
   wire logic serial_input_pin, serial_output_pin, serial_output_oe_n, rx_done_irq, tx_done_irq;
   int n_fail = 0;
   int checks_done = 0;
   int cycles = 0;
   int rx_cnt = 0;
   asu_core dut (.mclk(mclk), .srst(srst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
      .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .serial_input_pin(serial_input_pin),
      .external_baud_clock_pin(ext_ck), .serial_output_pin(serial_output_pin),
      .serial_output_oe_n(serial_output_oe_n), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq));
   asu_remote #(.BIT_NS(BIT)) remote (.line_in(serial_output_pin), .line_out(serial_input_pin));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // external baud source, 40 ns period
   initial begin
      ext_ck = 1'b0;
      forever #20 ext_ck = ~ext_ck;
   end
   task automatic end_sim();
      if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   always @(posedge mclk) begin
      cycles++;
      if (rx_done_irq === 1'b1) rx_cnt++;
      if (cycles == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      cpu_addr = a;
      cpu_wdata = d;
      cpu_wr = 1'b1;
      @(posedge mclk);
      #1;
      cpu_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      cpu_addr = a;
      cpu_rd = 1'b1;
      @(posedge mclk);
      #1;
      cpu_rd = 1'b0;
      d = cpu_rdata;
   endtask : rd
   task automatic rc(input logic [15:0] a, input logic [7:0] e, input string nm);
      rd(a, r);
      chk(nm, {4'h0, r}, {4'h0, e});
   endtask : rc
   // mode writes only between frames
   task automatic tx_case(input logic [7:0] m, input logic [7:0] d, input int n, input logic [11:0] e);
      wr(ASU_MODE_ADDR, m);
      wr(ASU_DATA_ADDR, d);
      remote.grab(n, v);
      chk("tx frame", v, e);
      #BIT;
   endtask : tx_case
   task automatic rx_case(input logic [7:0] m, input logic [7:0] d, input int nb, input int par,
      input logic stp, input logic [7:0] es, input int ei, input int rdm, input logic [7:0] eb);
      int n0;
      wr(ASU_MODE_ADDR, m);
      n0 = rx_cnt;
      remote.send(d, nb, par, stp);
      chk("rx irq", 12'(rx_cnt - n0), 12'(ei));
      rc(ASU_STAT_ADDR, es, "status");
      if (rdm != 0) rd(ASU_DATA_ADDR, r);
      if (rdm == 2) chk("rx buffer", {4'h0, r}, {4'h0, eb});
   endtask : rx_case
   initial begin
      srst = 1'b1;
      cpu_wr = 1'b0;
      cpu_rd = 1'b0;
      cpu_addr = 16'h0000;
      cpu_wdata = 8'h00;
      repeat (10) @(posedge mclk);
      #1;
      srst = 1'b0;
      rc(ASU_MODE_ADDR, 8'h00, "mode rst");
      rc(ASU_STAT_ADDR, 8'h00, "stat rst");
      rc(ASU_DATA_ADDR, 8'hff, "rxb rst");
      rc(16'hffa4, 8'h00, "unmapped");
      wr(ASU_STAT_ADDR, 8'h07);
      rc(ASU_STAT_ADDR, 8'h00, "stat ro");
      wr(ASU_MODE_ADDR, 8'h01);
      rc(ASU_MODE_ADDR, 8'h00, "mode b0");
      wr(ASU_BAUD_ADDR, 8'h00);
      wr(ASU_MODE_ADDR, 8'h88);
      wr(ASU_DATA_ADDR, 8'h00);
      #4000;
      chk("ext rate data", {11'h0, serial_output_pin}, 12'h000);
      #3000;
      chk("ext rate end", {11'h0, serial_output_pin}, 12'h001);
      wr(ASU_BAUD_ADDR, 8'h10);
      rc(ASU_BAUD_ADDR, 8'h10, "baud");
      wr(ASU_MODE_ADDR, 8'h40);
      wr(ASU_DATA_ADDR, 8'h00);
      repeat (40) @(posedge mclk);
      chk("tx off", {11'h0, serial_output_pin}, 12'h001);
      chk("tx oe off", {11'h0, serial_output_oe_n}, 12'h001);
      rc(ASU_DATA_ADDR, 8'hff, "rxb wr");
      tx_case(8'hcc, 8'ha5, 10, {2'b11, 8'ha5, 1'b0});
      tx_case(8'he0, 8'hff, 9, {2'b10, 7'h7f, 1'b0});
      tx_case(8'hf8, 8'h01, 10, {2'b11, 8'h01, 1'b0});
      tx_case(8'hd8, 8'hff, 10, {2'b10, 8'hff, 1'b0});
      rx_case(8'hcc, 8'h3c, 8, 0, 1, 8'h00, 1, 2, 8'h3c);
      rx_case(8'he0, 8'h55, 7, 2, 1, 8'h00, 1, 2, 8'h55);
      rx_case(8'hf8, 8'h01, 8, 1, 1, 8'h04, 1, 1, 8'h00);
      rx_case(8'hfa, 8'h01, 8, 1, 1, 8'h04, 0, 1, 8'h00);
      rx_case(8'hd8, 8'h81, 8, 2, 1, 8'h00, 1, 2, 8'h81);
      rx_case(8'hcc, 8'h00, 8, 0, 0, 8'h02, 1, 1, 8'h00);
      rx_case(8'hcc, 8'h11, 8, 0, 1, 8'h00, 1, 0, 8'h00);
      rx_case(8'hcc, 8'h22, 8, 0, 1, 8'h01, 1, 0, 8'h00);
      rx_case(8'hcc, 8'h33, 8, 0, 1, 8'h01, 1, 2, 8'h33);
      rx_case(8'hcc, 8'h44, 8, 0, 1, 8'h00, 1, 2, 8'h44);
      end_sim();
   end
endmodule : testbench
bind asu_core asu_core_asserts u_chk (.mclk(mclk), .srst(srst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
   .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .serial_input_pin(serial_input_pin),
   .external_baud_clock_pin(external_baud_clock_pin), .serial_output_pin(serial_output_pin),
   .serial_output_oe_n(serial_output_oe_n), .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq));
`default_nettype wire
